// [rtl/adc_seq_device.sv]
/*
  Converter-side control: control and shadow registers, input configuration
  decode, reference select and the channel sequencer driven by the start strobe.
  Assumes a host on adc_seq_if; strobes are asynchronous pins.
*/
`timescale 1ns/100ps
module adc_seq_device
  import adc_seq_pkg::*;
#(
  parameter int CONV_CYCLES = 16
) (
  input  wire logic            i_sys_clk,
  input  wire logic            i_rstn,
  adc_seq_if.device_end        link,
  output logic [CH_W-1:0]      o_pos_ch,
  output logic [CH_W-1:0]      o_neg_ch,
  output logic                 o_neg_is_common,
  output logic                 o_neg_is_ground,
  output logic                 o_internal_ref,
  output logic [1:0]           o_input_config,
  output logic                 o_sample_strobe,
  output logic [CH_W-1:0]      o_sampled_ch
);
  logic [SYNC_STAGES-1:0] wr_sync_r;
  logic [SYNC_STAGES-1:0] cs_sync_r;
  logic                   wr_n_r;
  logic                   cs_n_r;
  logic                   wr_rise;
  logic                   cs_fall;
  logic [CTRL_W-1:0]      data_r;
  logic                   shadow_sel_r;
  logic [CTRL_W-1:0]      ctrl_r;
  logic [SHADOW_W-1:0]    shadow_r;
  run_mode_t              mode_r;
  logic [CH_W-1:0]        ptr_r;
  logic [CH_W-1:0]        ptr_nxt;
  logic [CH_W-1:0]        last_ch_r;
  logic                   conv_done;
  logic [7:0]             conv_cnt_r;
  logic                   busy_r;
  logic [CH_W-1:0]        low_sel;
  logic [CH_W-1:0]        next_sel;
  logic                   next_found;
  logic [1:0]             wr_seq;
  logic                   ctrl_wr;
  logic                   shadow_wr;

  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      wr_sync_r <= '1;
      cs_sync_r <= '1;
      wr_n_r    <= 1'b1;
      cs_n_r    <= 1'b1;
    end else begin
      wr_sync_r <= {wr_sync_r[SYNC_STAGES-2:0], link.wr_n};
      cs_sync_r <= {cs_sync_r[SYNC_STAGES-2:0], link.conversion_start_n};
      if (wr_sync_r[1] == wr_sync_r[2])
        wr_n_r <= wr_sync_r[2];
      if (cs_sync_r[1] == cs_sync_r[2])
        cs_n_r <= cs_sync_r[2];
    end
  end

  // Data and target are held across the strobe, so sampling them while
  // the strobe is low keeps them aligned with the delayed rising edge
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      data_r       <= CTRL_RESET;
      shadow_sel_r <= 1'b0;
    end else if (!wr_n_r) begin
      data_r       <= link.data;
      shadow_sel_r <= link.shadow_sel;
    end
  end

  assign wr_rise   = !wr_n_r && wr_sync_r[1] && wr_sync_r[2];
  assign cs_fall   = cs_n_r && !cs_sync_r[1] && !cs_sync_r[2];
  assign ctrl_wr   = wr_rise && !shadow_sel_r;
  assign shadow_wr = wr_rise && shadow_sel_r;
  assign wr_seq    = {data_r[POS_SEQ], data_r[POS_SHADOW_ENABLE_BIT]};

  // Bits 1,0 leave the running program untouched
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn)
      ctrl_r <= CTRL_RESET;
    else if (ctrl_wr) begin
      ctrl_r <= data_r;
      if (wr_seq == SEQ_KEEP)
        ctrl_r[POS_SEQ:POS_SHADOW_ENABLE_BIT] <= ctrl_r[POS_SEQ:POS_SHADOW_ENABLE_BIT];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn)
      shadow_r <= SHADOW_RESET;
    else if (shadow_wr)
      shadow_r <= data_r[SHADOW_W-1:0];
  end

  // Lowest set bit, and next set bit above the pointer
  always_comb begin
    low_sel    = FIRST_CH;
    next_sel   = FIRST_CH;
    next_found = 1'b0;
    for (int i = SHADOW_W - 1; i >= 0; i--) begin
      if (shadow_r[i])
        low_sel = CH_W'(i);
      if (shadow_r[i] && CH_W'(i) > ptr_r) begin
        next_sel   = CH_W'(i);
        next_found = 1'b1;
      end
    end
  end

  always_comb begin
    ptr_nxt = ptr_r;
    case (mode_r)
      MODE_SINGLE: ptr_nxt = ctrl_r[POS_ADDR_MSB:POS_ADDR_LSB];
      MODE_PROG:   ptr_nxt = next_found ? next_sel : low_sel;
      MODE_CONSEC: ptr_nxt = (ptr_r >= last_ch_r) ? FIRST_CH
                                                  : ptr_r + 3'h1;
      default:     ptr_nxt = FIRST_CH;
    endcase
  end

  // Mode and pointer: control writes other than 1,0 and shadow writes in program mode restart; completed conversions advance outside single mode
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      mode_r    <= MODE_SINGLE;
      ptr_r     <= FIRST_CH;
      last_ch_r <= FIRST_CH;
    end else if (ctrl_wr && wr_seq != SEQ_KEEP) begin
      last_ch_r <= data_r[POS_ADDR_MSB:POS_ADDR_LSB];
      case (wr_seq)
        SEQ_PROG: begin
          mode_r <= MODE_PROG;
          ptr_r  <= low_sel;
        end
        SEQ_CONSEC: begin
          mode_r <= MODE_CONSEC;
          ptr_r  <= FIRST_CH;
        end
        default: begin
          mode_r <= MODE_SINGLE;
          ptr_r  <= data_r[POS_ADDR_MSB:POS_ADDR_LSB];
        end
      endcase
    end else if (shadow_wr && mode_r == MODE_PROG) begin
      ptr_r <= FIRST_CH;
      for (int i = SHADOW_W - 1; i >= 0; i--)
        if (data_r[i])
          ptr_r <= CH_W'(i);
    end else if (conv_done && mode_r != MODE_SINGLE) begin
      ptr_r <= ptr_nxt;
    end
  end

  // Conversion timer; done pulse comes once per started conversion
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      busy_r       <= 1'b0;
      conv_cnt_r   <= 8'h00;
      o_sampled_ch <= FIRST_CH;
    end else if (cs_fall && !busy_r) begin
      busy_r       <= 1'b1;
      conv_cnt_r   <= 8'(CONV_CYCLES - 1);
      o_sampled_ch <= ptr_r;
    end else if (busy_r) begin
      conv_cnt_r <= conv_cnt_r - 8'h01;
      if (conv_cnt_r == 8'h00)
        busy_r <= 1'b0;
    end
  end

  assign conv_done       = busy_r && conv_cnt_r == 8'h00;
  assign o_sample_strobe = cs_fall && !busy_r;
  assign link.busy       = busy_r;

  // Multiplexer pair from the input configuration
  always_comb begin
    o_input_config  = {ctrl_r[POS_CFG_LOW], ctrl_r[POS_CFG_HIGH]};
    o_internal_ref  = ctrl_r[POS_REF];
    o_pos_ch        = ptr_r;
    o_neg_ch        = COMMON_CH;
    o_neg_is_common = 1'b0;
    o_neg_is_ground = 1'b0;
    case (o_input_config)
      CFG_SINGLE_ENDED: o_neg_is_ground = 1'b1;
      CFG_FULL_DIFF: begin
        o_pos_ch = {ptr_r[1:0], 1'b0};
        o_neg_ch = {ptr_r[1:0], 1'b1};
      end
      CFG_PSEUDO_PAIRS: begin
        o_pos_ch = {ptr_r[1:0], 1'b0};
        o_neg_ch = {ptr_r[1:0], 1'b1};
      end
      CFG_PSEUDO_SEVEN: o_neg_is_common = 1'b1;
      default:          o_neg_is_ground = 1'b1;
    endcase
  end
endmodule // adc_seq_device

// [pkg/adc_seq_pkg.sv]
/*
  Shared constants for the converter input-channel sequencer and its host end:
  control word layout, sequencing modes, input configurations.
  Assumes a single 50 MHz system clock on both ends.
*/
package adc_seq_pkg;
  localparam int CTRL_W            = 12;
  localparam int SHADOW_W          = 8;
  localparam int CH_W              = 3;
  // Control word field positions
  localparam int POS_ADDR_LSB      = 0;
  localparam int POS_ADDR_MSB      = 2;
  localparam int POS_REF           = 3;
  localparam int POS_SHADOW_ENABLE_BIT          = 4;
  localparam int POS_SEQ           = 5;
  localparam int POS_CFG_LOW       = 6;
  localparam int POS_CFG_HIGH      = 7;
  localparam logic [CTRL_W-1:0]   CTRL_RESET   = 12'h000;
  localparam logic [SHADOW_W-1:0] SHADOW_RESET = 8'h00;
  localparam logic [CH_W-1:0]     COMMON_CH    = 3'h7;
  localparam logic [CH_W-1:0]     FIRST_CH     = 3'h0;
  // Sequencing bits as {sequence_select_bit, shadow_enable_bit}
  localparam logic [1:0] SEQ_SINGLE  = 2'h0;
  localparam logic [1:0] SEQ_PROG    = 2'h1;
  localparam logic [1:0] SEQ_KEEP    = 2'h2;
  localparam logic [1:0] SEQ_CONSEC  = 2'h3;
  // Input configurations as {input_config_bit_low, input_config_bit_high}
  localparam logic [1:0] CFG_SINGLE_ENDED = 2'h0;
  localparam logic [1:0] CFG_FULL_DIFF    = 2'h1;
  localparam logic [1:0] CFG_PSEUDO_PAIRS = 2'h2;
  localparam logic [1:0] CFG_PSEUDO_SEVEN = 2'h3;
  // Pin synchroniser depth
  localparam int SYNC_STAGES = 3;

  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_PROG,
    MODE_CONSEC
  } run_mode_t;
endpackage

// [pkg/adc_seq_if.sv]
/*
  Pins between the host and the converter control logic.
  Assumes both ends run on the same clock; the device still synchronises
  the strobes since on a board they come from pins.
*/
`timescale 1ns/100ps
interface adc_seq_if;
  import adc_seq_pkg::*;
  logic              wr_n;
  logic              shadow_sel;
  logic [CTRL_W-1:0] data;
  logic              conversion_start_n;
  logic              busy;

  modport device_end (
    input  wr_n,
    input  shadow_sel,
    input  data,
    input  conversion_start_n,
    output busy
  );
  modport host_end (
    output wr_n,
    output shadow_sel,
    output data,
    output conversion_start_n,
    input  busy
  );
endinterface

// [rtl/adc_seq_host.sv]
/*
  Host end: turns user requests into write strobes and start pulses.
  Assumes the device end on adc_seq_if and one shared clock.
*/
`timescale 1ns/100ps
module adc_seq_host
  import adc_seq_pkg::*;
#(
  parameter int STROBE_CYCLES = 4
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rstn,
  adc_seq_if.host_end            link,
  input  wire logic              i_wr_req,
  input  wire logic              i_wr_shadow,
  input  wire logic [CTRL_W-1:0] i_wr_data,
  input  wire logic              i_conv_req,
  output logic                   o_ready,
  output logic                   o_busy
);
  logic [7:0]             cnt_r;
  logic                   wr_n_r;
  logic                   cs_n_r;
  logic                   sel_r;
  logic [CTRL_W-1:0]      data_r;
  logic [SYNC_STAGES-1:0] busy_sync_r;
  logic                   busy_r;

  // Strobe low, then high, each for STROBE_CYCLES; data stays put after
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      cnt_r  <= 8'h00;
      wr_n_r <= 1'b1;
      cs_n_r <= 1'b1;
      sel_r  <= 1'b0;
      data_r <= CTRL_RESET;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
      if (cnt_r == 8'(STROBE_CYCLES + 1)) begin
        wr_n_r <= 1'b1;
        cs_n_r <= 1'b1;
      end
    end else if (i_wr_req) begin
      // Mid-sequence writes must carry bits 1,0 if the sequence is to go on
      wr_n_r <= 1'b0;
      sel_r  <= i_wr_shadow;
      data_r <= i_wr_data;
      cnt_r  <= 8'(2 * STROBE_CYCLES);
    end else if (i_conv_req && !busy_r) begin
      cs_n_r <= 1'b0;
      cnt_r  <= 8'(2 * STROBE_CYCLES);
    end
  end

  // Busy arrives over a pin; a change counts once stages two and three agree
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      busy_sync_r <= '0;
      busy_r      <= 1'b0;
    end else begin
      busy_sync_r <= {busy_sync_r[SYNC_STAGES-2:0], link.busy};
      if (busy_sync_r[1] == busy_sync_r[2])
        busy_r <= busy_sync_r[2];
    end
  end

  assign link.wr_n               = wr_n_r;
  assign link.shadow_sel         = sel_r;
  assign link.data               = data_r;
  assign link.conversion_start_n = cs_n_r;
  assign o_ready                 = cnt_r == 8'h00;
  assign o_busy                  = busy_r;
endmodule // adc_seq_host

// [sim/adc_seq_props.sv]
/* Pin checker for the host/device link of the sequencer.
   Assumes one clock and a sync active-low reset. */
`timescale 1ns/100ps
module adc_seq_props
  import adc_seq_pkg::*;
#(
  parameter int CONV_CYCLES   = 16,
  parameter int STROBE_CYCLES = 4
) (
  input wire logic              i_sys_clk,
  input wire logic              i_rstn,
  input wire logic              wr_n,
  input wire logic              shadow_sel,
  input wire logic [CTRL_W-1:0] data,
  input wire logic              conversion_start_n,
  input wire logic              busy
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  logic [7:0] bsy_r;
  logic [7:0] low_r;
  logic [7:0] age_r;
  logic       st_r;
  // Age saturates so a stray busy long after a start still fails
  always_ff @(posedge i_sys_clk) begin
    st_r  <= conversion_start_n;
    bsy_r <= busy ? bsy_r + 8'h01 : 8'h00;
    low_r <= wr_n ? 8'h00 : low_r + 8'h01;
    age_r <= !i_rstn ? 8'hff : (st_r && !conversion_start_n) ? 8'h00 :
             age_r + {7'h00, age_r != 8'hff};
  end
  sequence s_idle_start;
    $fell(conversion_start_n) && !busy;
  endsequence
  sequence s_two_low;
    !wr_n ##1 !wr_n;
  endsequence
  a_start_gets_busy: assert property (s_idle_start |-> ##[1:8] $rose(busy))
    else $error("no busy after start");
  a_busy_has_cause: assert property ($rose(busy) |-> age_r <= 8'h08)
    else $error("busy without start");
  a_conv_length: assert property ($fell(busy) |-> bsy_r == CONV_CYCLES)
    else $error("busy length wrong");
  a_busy_gap: assert property ($fell(busy) |=> !busy)
    else $error("busy rose at once");
  a_write_width: assert property ($rose(wr_n) |-> low_r == STROBE_CYCLES)
    else $error("write width wrong");
  a_write_stable: assert property (s_two_low |-> $stable(data) && $stable(shadow_sel))
    else $error("write data moved");
  a_start_no_write: assert property ($fell(conversion_start_n) |-> wr_n)
    else $error("start inside write");
  a_reset_idle: assert property ($rose(i_rstn) |-> wr_n && conversion_start_n)
    else $error("strobe low after reset");
endmodule // adc_seq_props

// [sim/adc_input_channel_sequencer_tb_top.sv]
/* Bench: host and device ends joined by the link, user side driven here.
   Assumes the package, the interface, the two ends and the adc_seq_props pin checker. */
`timescale 1ns/100ps
module adc_input_channel_sequencer_tb_top;
  import adc_seq_pkg::*;
  logic              clk;
  logic              rstn;
  logic              wreq;
  logic              wsh;
  logic [CTRL_W-1:0] wd;
  logic              creq;
  logic              rdy;
  logic              hb;
  logic [CH_W-1:0]   pch;
  logic [CH_W-1:0]   nch;
  logic              ncom;
  logic              ngnd;
  logic              iref;
  logic [1:0]        icfg;
  logic              stb;
  logic [CH_W-1:0]   sch;
  int                err_total;
  int                checked;
  adc_seq_if lk ();
  adc_seq_device #(.CONV_CYCLES(8)) adc_seq_device_i (.i_sys_clk(clk), .i_rstn(rstn),
    .link(lk.device_end), .o_pos_ch(pch), .o_neg_ch(nch), .o_neg_is_common(ncom),
    .o_neg_is_ground(ngnd), .o_internal_ref(iref), .o_input_config(icfg),
    .o_sample_strobe(stb), .o_sampled_ch(sch));
  adc_seq_host #(.STROBE_CYCLES(4)) adc_seq_host_i (.i_sys_clk(clk), .i_rstn(rstn),
    .link(lk.host_end), .i_wr_req(wreq), .i_wr_shadow(wsh), .i_wr_data(wd),
    .i_conv_req(creq), .o_ready(rdy), .o_busy(hb));
  adc_seq_props #(.CONV_CYCLES(8), .STROBE_CYCLES(4)) adc_seq_props_i (.i_sys_clk(clk),
    .i_rstn(rstn), .wr_n(lk.wr_n), .shadow_sel(lk.shadow_sel), .data(lk.data),
    .conversion_start_n(lk.conversion_start_n), .busy(lk.busy));
  task automatic close_out;
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(string s, logic [2:0] e, logic [2:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %0d seen %0d", s, e, g);
    end
  endtask
  function automatic logic [CTRL_W-1:0] cw(logic [1:0] c, logic [1:0] q, logic r,
                                           logic [2:0] a);
    return {4'h0, c[0], c[1], q[1], q[0], r, a};
  endfunction
  task automatic wr(logic s, logic [CTRL_W-1:0] w);
    int n;
    for (n = 0; n < 60 && rdy !== 1'b1; n++) @(negedge clk);
    wsh = s;
    wd = w;
    wreq = 1'b1;
    @(negedge clk);
    wreq = 1'b0;
    for (n = 0; n < 60 && rdy !== 1'b1; n++) @(negedge clk);
    chk("ready", 3'h1, {2'h0, rdy});
    // Device sees the strobe only after its pin synchroniser
    repeat (6) @(negedge clk);
  endtask
  task automatic cv(string s, logic [2:0] e);
    int n;
    for (n = 0; n < 60 && (rdy !== 1'b1 || hb !== 1'b0); n++) @(negedge clk);
    creq = 1'b1;
    @(negedge clk);
    creq = 1'b0;
    for (n = 0; n < 60 && stb !== 1'b1; n++) @(negedge clk);
    chk("strobe", 3'h1, {2'h0, stb});
    for (n = 0; n < 60 && hb !== 1'b1; n++) @(negedge clk);
    for (n = 0; n < 60 && hb !== 1'b0; n++) @(negedge clk);
    chk("busy", 3'h0, {2'h0, hb});
    chk(s, e, sch);
  endtask
  task automatic t_single;
    wr(1'b0, cw(CFG_SINGLE_ENDED, SEQ_SINGLE, 1'b1, 3'h5));
    chk("gnd", 3'h1, {2'h0, ngnd});
    chk("ref", 3'h1, {2'h0, iref});
    chk("pos", 3'h5, pch);
    cv("single", 3'h5);
    wr(1'b0, cw(CFG_SINGLE_ENDED, SEQ_SINGLE, 1'b0, 3'h2));
    chk("ref", 3'h0, {2'h0, iref});
    cv("single", 3'h2);
    $display("single done");
  endtask
  task automatic t_cfg;
    logic [1:0] c;
    for (int k = 0; k < 4; k++) begin
      c = 2'(k);
      wr(1'b0, cw(c, SEQ_SINGLE, 1'b0, 3'h1));
      chk("cfg", {1'b0, c}, {1'b0, icfg});
      chk("common", {2'h0, c == CFG_PSEUDO_SEVEN}, {2'h0, ncom});
      if (c == CFG_PSEUDO_SEVEN) chk("neg", COMMON_CH, nch);
      chk("gnd", {2'h0, c == CFG_SINGLE_ENDED}, {2'h0, ngnd});
      // Address 1 in a pair mode is pair 1: inputs 2 and 3
      chk("pos", (c == CFG_FULL_DIFF || c == CFG_PSEUDO_PAIRS) ? 3'h2 : 3'h1, pch);
      if (c == CFG_FULL_DIFF || c == CFG_PSEUDO_PAIRS) chk("neg", 3'h3, nch);
    end
    $display("config done");
  endtask
  task automatic t_prog;
    wr(1'b1, 12'h094);
    wr(1'b0, cw(CFG_SINGLE_ENDED, SEQ_PROG, 1'b0, 3'h0));
    cv("prog", 3'h2);
    cv("prog", 3'h4);
    cv("prog", 3'h7);
    cv("wrap", 3'h2);
    // Mid-run write that must leave the pointer alone
    wr(1'b0, cw(CFG_SINGLE_ENDED, SEQ_KEEP, 1'b0, 3'h0));
    cv("kept", 3'h4);
    // New shadow set while running restarts at its lowest channel
    wr(1'b1, 12'h028);
    cv("reload", 3'h3);
    cv("reload", 3'h5);
    cv("reload", 3'h3);
    wr(1'b0, cw(CFG_SINGLE_ENDED, SEQ_SINGLE, 1'b0, 3'h3));
    cv("ended", 3'h3);
    cv("ended", 3'h3);
    $display("prog done");
  endtask
  task automatic t_con;
    wr(1'b0, cw(CFG_SINGLE_ENDED, SEQ_CONSEC, 1'b0, 3'h2));
    cv("con", 3'h0);
    cv("con", 3'h1);
    cv("con", 3'h2);
    cv("con", 3'h0);
    wr(1'b0, cw(CFG_SINGLE_ENDED, SEQ_KEEP, 1'b0, 3'h0));
    cv("con", 3'h1);
    wr(1'b0, cw(CFG_SINGLE_ENDED, SEQ_CONSEC, 1'b0, 3'h0));
    cv("con", 3'h0);
    cv("con", 3'h0);
    $display("consec done");
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    rstn = 1'b0;
    wreq = 1'b0;
    wsh = 1'b0;
    wd = 12'h000;
    creq = 1'b0;
    err_total = 0;
    checked = 0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    t_single;
    t_cfg;
    t_prog;
    t_con;
    close_out;
  end
  // About six times the expected run
  initial begin
    #60000;
    err_total++;
    close_out;
  end
endmodule // adc_input_channel_sequencer_tb_top
